// ### hw/pmac_pkg.sv
// Package for the attribute command unit: offsets, codes, field layouts, timing
package pmac_pkg;

  // ==========================================================
  // Register offsets on the reconfiguration port
  localparam logic [7:0] OFS_ARG_LO = 8'h84;
  localparam logic [7:0] OFS_ARG_HI = 8'h85;
  localparam logic [7:0] OFS_CODE_LO = 8'h86;
  localparam logic [7:0] OFS_CODE_HI = 8'h87;
  localparam logic [7:0] OFS_RET_LO = 8'h88;
  localparam logic [7:0] OFS_RET_HI = 8'h89;
  localparam logic [7:0] OFS_SENT = 8'h8a;
  localparam logic [7:0] OFS_BUSY = 8'h8b;
  localparam logic [7:0] OFS_LOAD = 8'h90;
  localparam int SENT_BIT = 7;
  localparam int BUSY_BIT = 0;
  localparam int LOAD_BIT = 0;

  // ==========================================================
  // Attribute codes and return values
  localparam logic [15:0] CMD_PWR = 16'h0001;
  localparam logic [15:0] CMD_PRBS = 16'h0002;
  localparam logic [15:0] CMD_CMP = 16'h0003;
  localparam logic [15:0] CMD_TXDIV = 16'h0005;
  localparam logic [15:0] CMD_RXDIV = 16'h0006;
  localparam logic [15:0] CMD_LPBK = 16'h0008;
  localparam logic [15:0] CMD_TUNE = 16'h000a;
  localparam logic [15:0] CMD_SLIP = 16'h000e;
  localparam logic [15:0] CMD_CAL = 16'h0011;
  localparam logic [15:0] RET_FAIL = 16'h0000;
  localparam logic [15:0] RET_BAD = 16'h00ff;
  localparam logic [15:0] EQ_RST_ARG = 16'hffff;

  // ==========================================================
  // Field encodings
  localparam logic [3:0] TUNE_INIT = 4'h1;
  localparam logic [3:0] TUNE_FREEZE = 4'h2;
  localparam logic [3:0] TUNE_CONT = 4'h6;
  localparam logic [2:0] PAT_USER = 3'h7;
  localparam logic [2:0] RATE_MAX = 3'h3;
  localparam logic [2:0] SEL_RSV_A = 3'h1;
  localparam logic [2:0] SEL_RSV_B = 3'h5;
  localparam logic [2:0] SEL_ONES = 3'h7;
  localparam logic [7:0] RATIO_NONE = 8'h00;

  // ==========================================================
  // Timing: cycles the analog channel takes to act on a command
  localparam logic [3:0] EXEC_CYC = 4'h4;
  localparam int SLIP_TOT_W = 10;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    FS_IDLE = 3'h1,
    FS_XFER = 3'h2,
    FS_EXEC = 3'h4
  } pmac_fsm_t;

  typedef struct packed {
    logic [15:0] code;
    logic [15:0] arg;
  } pmac_mbox_t;

  typedef struct packed {
    logic [2:0] pat;
    logic gen_on;
    logic reseed;
    logic autoseed;
    logic stop_err;
    logic tx_load;
    logic rx_chk;
  } pmac_prbs_t;

  typedef struct packed {
    logic en;
    logic sum;
    logic [2:0] src;
    logic [2:0] tgt;
  } pmac_cmp_t;

  typedef struct packed {
    logic [7:0] ratio;
    logic [2:0] rate;
    logic slave;
    logic ref_b;
  } pmac_div_t;

endpackage : pmac_pkg

// ### hw/pmac_slip.sv
// Phase slip issue and accumulation for the attribute command unit
`timescale 1ns/1ns
`default_nettype none

module pmac_slip
  import pmac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic trig_i,
  input wire logic [5:0] cnt_i,
  input wire logic ana_rst_i,
  output logic go_o,
  output logic [5:0] amt_o,
  output logic [SLIP_TOT_W-1:0] total_o
);

  logic go_reg;
  logic go_next;
  logic [5:0] amt_reg;
  logic [5:0] amt_next;
  logic [SLIP_TOT_W-1:0] tot_reg;
  logic [SLIP_TOT_W-1:0] tot_next;

  // ==========================================================
  // Each slip trigger adds the count again; analog reset or rstn_i clears the total
  always_comb begin
    go_next = trig_i; // [RL15]
    amt_next = trig_i ? cnt_i : amt_reg;
    tot_next = tot_reg;
    if (ana_rst_i) begin
      tot_next = '0;
    end else if (trig_i) begin
      tot_next = tot_reg + SLIP_TOT_W'(cnt_i); // [RL16]
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      go_reg <= 1'b0;
      amt_reg <= '0;
      tot_reg <= '0;
    end else begin
      go_reg <= go_next;
      amt_reg <= amt_next;
      tot_reg <= tot_next;
    end
  end

  assign go_o = go_reg;
  assign amt_o = amt_reg;
  assign total_o = tot_reg;

  // ==========================================================
  slip_add_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RL16]
    trig_i && !ana_rst_i |=> total_o == $past(total_o) + SLIP_TOT_W'($past(cnt_i)))
    else $error("slip total did not accumulate");

endmodule : pmac_slip

`default_nettype wire

// ### hw/pmac_unit.sv
// Attribute command unit: mailbox registers, command sequencer and decode
//
// Notes on behaviour
// [RL1] Host writes code to upper mailbox bytes, argument to lower bytes first.
// [RL2] Power argument bits 0,1,2 enable transmitter, receiver, output driver.
// [RL3] Power command returns its own code once settings are taken.
// [RL4] Pattern selector 0-6 picks PRBS polynomial; 7 picks user pattern, PRBS off.
// [RL5] Pattern bits: reseed, autoseed, stop on error, load generator, enable checker.
// [RL6] Pattern and compare return zero when background busy, else own code.
// [RL7] Compare bit 0 enables, bit 1 picks ratio or sum comparison.
// [RL8] Compare source selector in low byte bits 6:4 picks data source.
// [RL9] Compare target selector in high byte bits 2:0, ones not allowed.
// [RL10] Transmit divider: ratio in low byte, rate code in high bits 2:0.
// [RL11] Divider high bits: 4 bonded slave, 6 reference B, 7 both directions.
// [RL12] Receive divider mirrors transmit; invalid returns 0x00FF; only while stopped. The unit accepts it in any power state.
// [RL13] Loopback bits change only with their enable bit; one mode at most.
// [RL14] Tuning: 1 initial, 2 freeze, 6 continuous; all ones resets equalization.
// [RL15] Phase slip takes 6-bit count; auto bit applies it on receiver enable.
// [RL16] Slips add up over repeated enables until an analog reset.
// [RL17] Host should pick slip counts matching the receive interface width.
// [RL18] Calibration marks transmit or receive path for recalibration at next enable.
// [RL19] Writing one to the load bit sends the mailbox as one command.
// [RL20] A status bit shows the command reached the analog channel.
// [RL21] Busy reads zero once the command finished and return value is valid.
// [RL22] Host waits for busy low before changing mailbox or loading again.
`timescale 1ns/1ns
`default_nettype none

module pmac_unit
  import pmac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_rd_i,
  output logic [7:0] bus_rdata_o,
  output logic bus_rvalid_o,
  input wire logic bg_busy_i,
  input wire logic ana_rst_i,
  output logic tx_en_o,
  output logic rx_en_o,
  output logic tx_out_en_o,
  output var pmac_prbs_t prbs_o,
  output var pmac_cmp_t cmp_o,
  output var pmac_div_t tx_div_o,
  output var pmac_div_t rx_div_o,
  output logic lb_ser_o,
  output logic lb_rpl_o,
  output logic eq_init_o,
  output logic eq_cont_o,
  output logic eq_rst_o,
  output logic tx_cal_o,
  output logic rx_cal_o,
  output logic slip_go_o,
  output logic [5:0] slip_amt_o,
  output logic [SLIP_TOT_W-1:0] slip_total_o
);

  // ==========================================================
  // Decode helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic sel_ok(input logic [2:0] s, input logic tgt);
    sel_ok = (s != SEL_RSV_A) && (s != SEL_RSV_B) && !(tgt && s == SEL_ONES);
  endfunction : sel_ok

  // ==========================================================
  // State
  pmac_fsm_t fsm_reg;
  pmac_fsm_t fsm_next;
  pmac_mbox_t mb_reg;
  pmac_mbox_t mb_next;
  logic [15:0] ret_reg;
  logic [15:0] ret_next;
  logic sent_reg;
  logic sent_next;
  logic busy_reg;
  logic busy_next;
  logic [3:0] wcnt_reg;
  logic [3:0] wcnt_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  logic [2:0] pwr_reg;
  logic [2:0] pwr_next;
  pmac_prbs_t prbs_reg;
  pmac_prbs_t prbs_next;
  pmac_cmp_t cmp_reg;
  pmac_cmp_t cmp_next;
  pmac_div_t txd_reg;
  pmac_div_t txd_next;
  pmac_div_t rxd_reg;
  pmac_div_t rxd_next;
  logic [1:0] lb_reg;
  logic [1:0] lb_next;
  logic eqc_reg;
  logic eqc_next;
  logic [1:0] calp_reg;
  logic [1:0] calp_next;
  logic [5:0] slc_reg;
  logic [5:0] slc_next;
  logic sla_reg;
  logic sla_next;
  // Single-cycle strobes: eq init, eq reset, tx cal, rx cal, slip trigger
  logic [4:0] stb_reg;
  logic [4:0] stb_next;

  logic load_acc;
  logic exec_done;
  logic [7:0] lo;
  logic [7:0] hi;

  assign lo = mb_reg.arg[7:0];
  assign hi = mb_reg.arg[15:8];
  assign exec_done = (fsm_reg == FS_EXEC) && (wcnt_reg == '0);
  assign load_acc = bus_wr_i && hit(bus_addr_i, OFS_LOAD)
    && bus_wdata_i[LOAD_BIT] && (fsm_reg == FS_IDLE); // [RL19]

  // ==========================================================
  // Register port: mailbox writes and read-back
  always_comb begin
    mb_next = mb_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    // Mailbox is frozen while a command is in flight so the channel sees a stable word
    if (bus_wr_i && !busy_reg) begin
      if (hit(bus_addr_i, OFS_ARG_LO)) begin
        mb_next.arg[7:0] = bus_wdata_i; // [RL1]
      end
      if (hit(bus_addr_i, OFS_ARG_HI)) begin
        mb_next.arg[15:8] = bus_wdata_i; // [RL1]
      end
      if (hit(bus_addr_i, OFS_CODE_LO)) begin
        mb_next.code[7:0] = bus_wdata_i; // [RL1]
      end
      if (hit(bus_addr_i, OFS_CODE_HI)) begin
        mb_next.code[15:8] = bus_wdata_i; // [RL1]
      end
    end
    if (bus_rd_i) begin
      rvalid_next = 1'b1;
      rdata_next = 8'h00;
      if (hit(bus_addr_i, OFS_ARG_LO)) begin
        rdata_next = mb_reg.arg[7:0];
      end
      if (hit(bus_addr_i, OFS_ARG_HI)) begin
        rdata_next = mb_reg.arg[15:8];
      end
      if (hit(bus_addr_i, OFS_CODE_LO)) begin
        rdata_next = mb_reg.code[7:0];
      end
      if (hit(bus_addr_i, OFS_CODE_HI)) begin
        rdata_next = mb_reg.code[15:8];
      end
      if (hit(bus_addr_i, OFS_RET_LO)) begin
        rdata_next = ret_reg[7:0];
      end
      if (hit(bus_addr_i, OFS_RET_HI)) begin
        rdata_next = ret_reg[15:8];
      end
      if (hit(bus_addr_i, OFS_SENT)) begin
        rdata_next[SENT_BIT] = sent_reg; // [RL20]
      end
      if (hit(bus_addr_i, OFS_BUSY)) begin
        rdata_next[BUSY_BIT] = busy_reg; // [RL21]
      end
    end
  end

  // ==========================================================
  // Sequencer and attribute decode
  always_comb begin
    pmac_div_t dv;
    logic [1:0] lbn;
    dv = '0;
    lbn = lb_reg;
    fsm_next = fsm_reg;
    ret_next = ret_reg;
    sent_next = sent_reg;
    busy_next = busy_reg;
    wcnt_next = wcnt_reg;
    pwr_next = pwr_reg;
    prbs_next = prbs_reg;
    cmp_next = cmp_reg;
    txd_next = txd_reg;
    rxd_next = rxd_reg;
    lb_next = lb_reg;
    eqc_next = eqc_reg;
    calp_next = calp_reg;
    slc_next = slc_reg;
    sla_next = sla_reg;
    stb_next = '0;
    unique case (fsm_reg)
      FS_IDLE: begin
        if (load_acc) begin
          busy_next = 1'b1; // [RL22]
          sent_next = 1'b0;
          fsm_next = FS_XFER;
        end
      end
      FS_XFER: begin
        sent_next = 1'b1; // [RL20]
        wcnt_next = EXEC_CYC - 4'h1;
        fsm_next = FS_EXEC;
      end
      FS_EXEC: begin
        if (wcnt_reg != '0) begin
          wcnt_next = wcnt_reg - 4'h1;
        end else begin
          busy_next = 1'b0; // [RL21]
          fsm_next = FS_IDLE;
          ret_next = mb_reg.code;
          unique case (mb_reg.code)
            CMD_PWR: begin
              pwr_next = lo[2:0]; // [RL2] [RL3]
              if (lo[0] && !pwr_reg[0] && calp_reg[0]) begin
                stb_next[2] = 1'b1; // [RL18]
                calp_next[0] = 1'b0;
              end
              if (lo[1] && !pwr_reg[1]) begin
                if (calp_reg[1]) begin
                  stb_next[3] = 1'b1; // [RL18]
                  calp_next[1] = 1'b0;
                end
                stb_next[4] = sla_reg; // [RL15] [RL16]
              end
            end
            CMD_PRBS: begin
              if (bg_busy_i) begin
                ret_next = RET_FAIL; // [RL6]
              end else begin
                prbs_next.pat = lo[2:0]; // [RL4]
                prbs_next.gen_on = (lo[2:0] != PAT_USER); // [RL4]
                prbs_next.reseed = lo[4]; // [RL5]
                prbs_next.autoseed = lo[5]; // [RL5]
                prbs_next.stop_err = lo[7]; // [RL5]
                prbs_next.tx_load = hi[0]; // [RL5]
                prbs_next.rx_chk = hi[1]; // [RL5]
              end
            end
            CMD_CMP: begin
              // Reserved selector codes are refused like a busy channel
              if (bg_busy_i || !sel_ok(lo[6:4], 1'b0) || !sel_ok(hi[2:0], 1'b1)) begin
                ret_next = RET_FAIL; // [RL6] [RL9]
              end else begin
                cmp_next.en = lo[0]; // [RL7]
                cmp_next.sum = lo[1]; // [RL7]
                cmp_next.src = lo[6:4]; // [RL8]
                cmp_next.tgt = hi[2:0]; // [RL9]
              end
            end
            CMD_TXDIV, CMD_RXDIV: begin
              if (hi[2:0] > RATE_MAX || lo == RATIO_NONE) begin
                ret_next = RET_BAD; // [RL12]
              end else begin
                dv.ratio = lo; // [RL10]
                dv.rate = hi[2:0]; // [RL10]
                dv.slave = hi[4]; // [RL11]
                dv.ref_b = hi[6]; // [RL11]
                if (mb_reg.code == CMD_TXDIV || hi[7]) begin
                  txd_next = dv; // [RL11]
                end
                if (mb_reg.code == CMD_RXDIV || hi[7]) begin
                  rxd_next = dv; // [RL12]
                end
              end
            end
            CMD_LPBK: begin
              if (hi[0]) begin
                lbn[0] = lo[0]; // [RL13]
              end
              if (hi[1]) begin
                lbn[1] = lo[4]; // [RL13]
              end
              // Newly selected mode displaces the other; a double request changes nothing
              if (lbn == 2'b11) begin
                if (hi[0] && hi[1]) begin
                  lbn = lb_reg; // [RL13]
                end else if (hi[0]) begin
                  lbn[1] = 1'b0; // [RL13]
                end else begin
                  lbn[0] = 1'b0; // [RL13]
                end
              end
              lb_next = lbn;
            end
            CMD_TUNE: begin
              if (mb_reg.arg == EQ_RST_ARG) begin
                stb_next[1] = 1'b1; // [RL14]
              end else if (lo[3:0] == TUNE_INIT) begin
                stb_next[0] = 1'b1; // [RL14]
              end else if (lo[3:0] == TUNE_FREEZE) begin
                eqc_next = 1'b0; // [RL14]
              end else if (lo[3:0] == TUNE_CONT) begin
                eqc_next = 1'b1; // [RL14]
              end
            end
            CMD_SLIP: begin
              slc_next = hi[5:0]; // [RL15]
              sla_next = hi[7]; // [RL15]
            end
            CMD_CAL: begin
              calp_next = calp_reg | lo[1:0]; // [RL18]
            end
            default: begin
              ret_next = RET_FAIL;
            end
          endcase
        end
      end
      default: begin
        fsm_next = FS_IDLE;
      end
    endcase
  end

  // ==========================================================
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fsm_reg <= FS_IDLE;
      mb_reg <= '0;
      ret_reg <= '0;
      sent_reg <= 1'b0;
      busy_reg <= 1'b0;
      wcnt_reg <= '0;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
      pwr_reg <= '0;
      prbs_reg <= '0;
      cmp_reg <= '0;
      txd_reg <= '0;
      rxd_reg <= '0;
      lb_reg <= '0;
      eqc_reg <= 1'b0;
      calp_reg <= '0;
      slc_reg <= '0;
      sla_reg <= 1'b0;
      stb_reg <= '0;
    end else begin
      fsm_reg <= fsm_next;
      mb_reg <= mb_next;
      ret_reg <= ret_next;
      sent_reg <= sent_next;
      busy_reg <= busy_next;
      wcnt_reg <= wcnt_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      pwr_reg <= pwr_next;
      prbs_reg <= prbs_next;
      cmp_reg <= cmp_next;
      txd_reg <= txd_next;
      rxd_reg <= rxd_next;
      lb_reg <= lb_next;
      eqc_reg <= eqc_next;
      calp_reg <= calp_next;
      slc_reg <= slc_next;
      sla_reg <= sla_next;
      stb_reg <= stb_next;
    end
  end

  // ==========================================================
  // Slip issue and running total
  pmac_slip u_slip (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .trig_i(stb_reg[4]),
    .cnt_i(slc_reg),
    .ana_rst_i(ana_rst_i),
    .go_o(slip_go_o),
    .amt_o(slip_amt_o),
    .total_o(slip_total_o)
  );

  // ==========================================================
  // Outputs
  assign bus_rdata_o = rdata_reg;
  assign bus_rvalid_o = rvalid_reg;
  assign tx_en_o = pwr_reg[0];
  assign rx_en_o = pwr_reg[1];
  assign tx_out_en_o = pwr_reg[2];
  assign prbs_o = prbs_reg;
  assign cmp_o = cmp_reg;
  assign tx_div_o = txd_reg;
  assign rx_div_o = rxd_reg;
  assign lb_ser_o = lb_reg[0];
  assign lb_rpl_o = lb_reg[1];
  assign eq_init_o = stb_reg[0];
  assign eq_rst_o = stb_reg[1];
  assign eq_cont_o = eqc_reg;
  assign tx_cal_o = stb_reg[2];
  assign rx_cal_o = stb_reg[3];

  // ==========================================================
  // Checks
  localparam int DONE_LAT = 6;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  load_busy_a: assert property (load_acc |=> busy_reg && fsm_reg == FS_XFER) // [RL19]
    else $error("load not taken");
  sent_flag_a: assert property (load_acc |=> !sent_reg ##1 sent_reg) // [RL20]
    else $error("sent flag wrong");
  busy_done_a: assert property (load_acc |-> ##DONE_LAT !busy_reg ##0 ret_reg == $past(mb_reg.code, 2)
    || ret_reg == RET_FAIL || ret_reg == RET_BAD) // [RL21]
    else $error("busy did not clear in time");
  pwr_ret_a: assert property (exec_done && mb_reg.code == CMD_PWR
    |=> ret_reg == CMD_PWR && tx_en_o == $past(lo[0]) && rx_en_o == $past(lo[1])) // [RL3]
    else $error("power command not applied");
  prbs_bg_a: assert property (exec_done && mb_reg.code == CMD_PRBS && bg_busy_i
    |=> ret_reg == RET_FAIL && $stable(prbs_o)) // [RL6]
    else $error("busy pattern command not refused");
  div_bad_a: assert property (exec_done && mb_reg.code == CMD_TXDIV && hi[2:0] > RATE_MAX
    |=> ret_reg == RET_BAD && $stable(tx_div_o)) // [RL12]
    else $error("bad divider accepted");
  lb_one_a: assert property (!(lb_ser_o && lb_rpl_o)) // [RL13]
    else $error("two loopback modes on");
  slip_en_a: assert property ($rose(rx_en_o) && sla_reg |=> slip_go_o && slip_amt_o == slc_reg) // [RL15]
    else $error("slip not issued on enable");
  cal_rx_a: assert property ($rose(rx_en_o) && $past(calp_reg[1]) |-> rx_cal_o ##1 !calp_reg[1]) // [RL18]
    else $error("receive calibration missed");
  mbox_hold_a: assert property (busy_reg |=> $stable(mb_reg)) // [RL22]
    else $error("mailbox changed while busy");

endmodule : pmac_unit

`default_nettype wire

// ### testbench/pmac_host.sv
// Host master model for the reconfiguration port of the attribute command unit
`timescale 1ns/1ns
`default_nettype none

module pmac_host
  import pmac_pkg::*;
(
  input wire logic clk_i,
  output logic [7:0] bus_addr_o,
  output logic bus_wr_o,
  output logic [7:0] bus_wdata_o,
  output logic bus_rd_o
);
  // ==========================================================
  // Expected read data, oldest first
  logic [7:0] exp_q[$];

  initial begin
    bus_addr_o = 8'h00;
    bus_wr_o = 1'b0;
    bus_wdata_o = 8'h00;
    bus_rd_o = 1'b0;
  end

  // ==========================================================
  // Bus cycles: idle lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_addr_o <= a;
    bus_wdata_o <= d;
    bus_wr_o <= 1'b1;
    @(posedge clk_i);
    bus_wr_o <= 1'b0;
    bus_addr_o <= ~a;
    bus_wdata_o <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    bus_addr_o <= a;
    bus_rd_o <= 1'b1;
    @(posedge clk_i);
    bus_rd_o <= 1'b0;
    bus_addr_o <= ~a;
  endtask : rd

  // ==========================================================
  // One full command; mailbox untouched until busy reads low
  task automatic cmd(input logic [15:0] code, input logic [15:0] arg, input logic [15:0] ret);
    wr(OFS_CODE_HI, code[15:8]);
    wr(OFS_CODE_LO, code[7:0]);
    wr(OFS_ARG_HI, arg[15:8]);
    wr(OFS_ARG_LO, arg[7:0]);
    wr(OFS_LOAD, 8'h01);
    rd(OFS_BUSY, 8'h01);
    rd(OFS_SENT, 8'h80);
    repeat (2) @(posedge clk_i);
    rd(OFS_BUSY, 8'h00);
    rd(OFS_RET_LO, ret[7:0]);
    rd(OFS_RET_HI, ret[15:8]);
  endtask : cmd
endmodule : pmac_host

`default_nettype wire

// ### testbench/pmac_attribute_command_unit_tb_top.sv
// Self-checking bench for the attribute command unit
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module pmac_attribute_command_unit_tb_top
  import pmac_pkg::*;
;
  // ==========================================================
  // Signals
  logic clk_i, rstn_i, bg_busy, ana_rst, wr, rd, rvalid;
  logic [7:0] addr, wdata, rdata, ev;
  logic tx_en, rx_en, tx_out_en, lb_ser, lb_rpl, eq_init, eq_cont, eq_rst, tx_cal, rx_cal, slip_go;
  pmac_prbs_t prbs, ep;
  pmac_cmp_t cmp;
  pmac_div_t tx_div, rx_div, d;
  logic [5:0] slip_amt;
  logic [SLIP_TOT_W-1:0] slip_total;
  logic [2:0] p, q;
  logic [2:0] srcs[6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  logic [31:0] seed = 32'he268;
  int n_errors = 0, check_count = 0, cyc = 0;
  int n_init = 0, n_rst = 0, n_txc = 0, n_rxc = 0, n_slip = 0;

  pmac_unit dut (.clk_i(clk_i), .rstn_i(rstn_i), .bus_addr_i(addr), .bus_wr_i(wr), .bus_wdata_i(wdata),
    .bus_rd_i(rd), .bus_rdata_o(rdata), .bus_rvalid_o(rvalid), .bg_busy_i(bg_busy), .ana_rst_i(ana_rst),
    .tx_en_o(tx_en), .rx_en_o(rx_en), .tx_out_en_o(tx_out_en), .prbs_o(prbs), .cmp_o(cmp),
    .tx_div_o(tx_div), .rx_div_o(rx_div), .lb_ser_o(lb_ser), .lb_rpl_o(lb_rpl), .eq_init_o(eq_init),
    .eq_cont_o(eq_cont), .eq_rst_o(eq_rst), .tx_cal_o(tx_cal), .rx_cal_o(rx_cal), .slip_go_o(slip_go),
    .slip_amt_o(slip_amt), .slip_total_o(slip_total));

  pmac_host host (.clk_i(clk_i), .bus_addr_o(addr), .bus_wr_o(wr), .bus_wdata_o(wdata), .bus_rd_o(rd));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic close_out();
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ==========================================================
  // Watcher: read answers against the oldest note, pulse counts
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
    if (rvalid === 1'b1) begin
      ev = host.exp_q.pop_front();
      `CHK(rdata, ev)
    end
    n_init += int'(eq_init === 1'b1);
    n_rst += int'(eq_rst === 1'b1);
    n_txc += int'(tx_cal === 1'b1);
    n_rxc += int'(rx_cal === 1'b1);
    n_slip += int'(slip_go === 1'b1);
  end

  // ==========================================================
  // Main sequence
  initial begin
    rstn_i = 1'b0;
    bg_busy = 1'b0;
    ana_rst = 1'b0;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    host.rd(OFS_RET_LO, 8'h00);
    host.rd(8'h80, 8'h00);
    host.wr(OFS_RET_HI, 8'h5a);
    host.rd(OFS_RET_HI, 8'h00);
    host.cmd(16'h0004, 16'h0000, RET_FAIL);
    host.cmd(CMD_CAL, 16'h0003, CMD_CAL);
    host.cmd(CMD_PWR, 16'h0003, CMD_PWR);
    `CHK({n_txc, n_rxc}, {32'd1, 32'd1})
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      host.cmd(CMD_PWR, {13'h0000, seed[2:0]}, CMD_PWR);
      `CHK({tx_out_en, rx_en, tx_en}, seed[2:0])
    end
    for (int s = 0; s < 8; s++) begin
      p = 3'(s);
      ep = '{pat: p, gen_on: p != PAT_USER, reseed: p[0], autoseed: p[1], stop_err: ~p[2],
        tx_load: ~p[0], rx_chk: p[0]};
      host.cmd(CMD_PRBS, {6'h00, p[0], ~p[0], ~p[2], 1'b0, p[1], p[0], 1'b0, p}, CMD_PRBS);
      `CHK(prbs, ep)
    end
    // Background activity refuses both, settings must stay put
    bg_busy <= 1'b1;
    host.cmd(CMD_PRBS, 16'h0000, RET_FAIL);
    host.cmd(CMD_CMP, 16'h0001, RET_FAIL);
    bg_busy <= 1'b0;
    `CHK(prbs.pat, PAT_USER)
    foreach (srcs[k]) begin
      p = srcs[k];
      q = (p == SEL_ONES) ? 3'h6 : p;
      host.cmd(CMD_CMP, {5'h00, q, 1'b0, p, 2'b00, p[0], 1'b1}, CMD_CMP);
      `CHK(cmp, {1'b1, p[0], p, q})
    end
    host.cmd(CMD_CMP, 16'h0701, RET_FAIL);
    host.cmd(CMD_PWR, 16'h0000, CMD_PWR);
    for (int r = 0; r < 4; r++) begin
      seed = xs(seed);
      d = {seed[7:0] | 8'h01, 3'(r), seed[8], seed[9]};
      host.cmd(CMD_TXDIV, {1'b0, d[0], 1'b0, d[1], 1'b0, d[4:2], d[12:5]}, CMD_TXDIV);
      `CHK(tx_div, d)
    end
    host.cmd(CMD_TXDIV, 16'h8121, CMD_TXDIV);
    `CHK(rx_div, {8'h21, 3'h1, 2'b00})
    host.cmd(CMD_RXDIV, 16'h4210, CMD_RXDIV);
    `CHK(rx_div, {8'h10, 3'h2, 2'b01})
    host.cmd(CMD_RXDIV, 16'h0410, RET_BAD);
    `CHK(rx_div.rate, 3'h2)
    host.cmd(CMD_TXDIV, 16'h0410, RET_BAD);
    `CHK(tx_div, {8'h21, 3'h1, 2'b00})
    host.cmd(CMD_LPBK, 16'h0301, CMD_LPBK);
    `CHK({lb_ser, lb_rpl}, 2'b10)
    host.cmd(CMD_LPBK, 16'h0210, CMD_LPBK);
    `CHK({lb_ser, lb_rpl}, 2'b01)
    host.cmd(CMD_LPBK, 16'h0001, CMD_LPBK);
    `CHK({lb_ser, lb_rpl}, 2'b01)
    host.cmd(CMD_TUNE, {12'h000, TUNE_INIT}, CMD_TUNE);
    host.cmd(CMD_TUNE, {12'h000, TUNE_CONT}, CMD_TUNE);
    `CHK({n_init, eq_cont}, {32'd1, 1'b1})
    host.cmd(CMD_TUNE, {12'h000, TUNE_FREEZE}, CMD_TUNE);
    host.cmd(CMD_TUNE, EQ_RST_ARG, CMD_TUNE);
    `CHK({n_rst, eq_cont}, {32'd1, 1'b0})
    // Twelve slips suit a sixteen bit NRZ receive width
    host.cmd(CMD_SLIP, {2'b10, 6'd12, 8'h00}, CMD_SLIP);
    repeat (2) begin
      host.cmd(CMD_PWR, 16'h0002, CMD_PWR);
      host.cmd(CMD_PWR, 16'h0000, CMD_PWR);
    end
    `CHK({n_slip, slip_amt}, {32'd2, 6'd12})
    `CHK(slip_total, SLIP_TOT_W'(24))
    ana_rst <= 1'b1;
    @(posedge clk_i);
    ana_rst <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(slip_total, SLIP_TOT_W'(0))
    close_out();
  end
endmodule : pmac_attribute_command_unit_tb_top

`default_nettype wire
